// [rtl/vapgo_regs.sv]
// pll divider, clock generator, phase, gain and offset register bank
//
// Notes on behaviour
// - read-only silicon revision at address zero
// - 12-bit divide ratio from 0x01 and 0x02[7:4]
// - divide ratio resets to 1693, high 0x69
// - ratio applied only when low register written
// - 0x03[7:6] selects clock generator range, reset 01
// - post-divider follows the range code automatically
// - 0x03[5:3] charge pump current code, reset 001
// - 0x03[2] picks external clock, reset 0
// - external clock ignores ratio, keeps phase
// - 0x04[7:3] phase, 32 steps, reset 16
// - 9-bit gain per channel, 511 full range
// - gain high staged until low register written
// - gain high resets 1000000, low 00
// - manual offset is nine bits, -256 to +255
// - auto offset is 11-bit signed clamp target
// - offset step of one moves output one code
// - offset high bytes applied on low write
`timescale 1ns/1ps
`default_nettype none

module vapgo_regs #(
    parameter logic [7:0] SILICON_REVISION = 8'h5a // arbitrary value
) (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // register access from the serial port engine
    input wire logic [vapgo_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [vapgo_pkg::DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_RD_I,
    output logic [vapgo_pkg::DATA_W-1:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    // offset mode from the auto-offset enable bit
    input wire logic AUTO_OFFSET_EN_I,
    // clock generator controls
    output logic [vapgo_pkg::RATIO_W-1:0] LINE_DIVIDE_RATIO_O,
    output logic LINE_DIVIDE_RATIO_USED_O,
    output logic [vapgo_pkg::RANGE_W-1:0] VCO_RANGE_O,
    output logic [vapgo_pkg::RANGE_W-1:0] POST_DIVIDE_SHIFT_O,
    output logic [vapgo_pkg::PUMP_W-1:0] PUMP_CURRENT_CODE_O,
    output logic [vapgo_pkg::PUMP_UA_W-1:0] PUMP_CURRENT_UA_O,
    output logic EXTERNAL_PIXEL_CLOCK_SEL_O,
    // sampling phase
    output logic [vapgo_pkg::PHASE_W-1:0] SAMPLE_PHASE_O,
    output logic [vapgo_pkg::PHASE_CDEG_W-1:0] SAMPLE_PHASE_CDEG_O,
    // channel gains
    output logic [vapgo_pkg::GAIN_W-1:0] RED_GAIN_O,
    output logic [vapgo_pkg::GAIN_W-1:0] GREEN_GAIN_O,
    output logic [vapgo_pkg::GAIN_W-1:0] BLUE_GAIN_O,
    // channel offsets, signed, mode resolved
    output logic AUTO_OFFSET_MODE_O,
    output logic [vapgo_pkg::OFFSET_W-1:0] RED_OFFSET_O,
    output logic [vapgo_pkg::OFFSET_W-1:0] GREEN_OFFSET_O,
    output logic [vapgo_pkg::OFFSET_W-1:0] BLUE_OFFSET_O
);
    import vapgo_pkg::*;

    // address of a channel register
    function automatic logic [7:0] chan_addr(input logic [7:0] base, input int ch,
                                             input logic low);
        logic [7:0] a;
        a = base + 8'(ch) * ADDR_CHANNEL_STRIDE;
        chan_addr = low ? a + ADDR_LOW_STEP : a;
    endfunction

    // charge pump current lookup
    function automatic logic [10:0] pump_ua(input logic [2:0] code);
        logic [10:0] ua;
        ua = PUMP_UA_0;
        unique case (code)
            3'h0: ua = PUMP_UA_0;
            3'h1: ua = PUMP_UA_1;
            3'h2: ua = PUMP_UA_2;
            3'h3: ua = PUMP_UA_3;
            3'h4: ua = PUMP_UA_4;
            3'h5: ua = PUMP_UA_5;
            3'h6: ua = PUMP_UA_6;
            3'h7: ua = PUMP_UA_7;
        endcase
        pump_ua = ua;
    endfunction

    // offset value as seen by the channel, sign extended to 11 bits
    function automatic logic [10:0] offset_resolve(input logic [10:0] raw, input logic auto_en);
        logic [8:0] manual;
        manual = raw[OFFSET_W-2 -: OFFSET_MANUAL_W];
        if (auto_en) begin
            offset_resolve = raw;
        end else begin
            offset_resolve = {{(OFFSET_W-OFFSET_MANUAL_W){manual[8]}}, manual};
        end
    endfunction

    logic wr_ratio_high;
    logic wr_ratio_low;
    logic wr_clk_ctl;
    logic wr_phase;

    logic [7:0] ratio_high_r;
    logic [3:0] ratio_low_r;
    logic [11:0] ratio_active_r;
    logic [1:0] range_r;
    logic [2:0] pump_r;
    logic ext_clock_r;
    logic [4:0] phase_r;

    logic [6:0] gain_high_r [NUM_CHANNELS];
    logic [1:0] gain_low_r [NUM_CHANNELS];
    logic [8:0] gain_active_r [NUM_CHANNELS];
    logic [7:0] offset_high_r [NUM_CHANNELS];
    logic [2:0] offset_low_r [NUM_CHANNELS];
    logic [10:0] offset_raw_r [NUM_CHANNELS];
    logic [10:0] offset_out_r [NUM_CHANNELS];

    logic [7:0] rdata_nxt;
    logic [7:0] chan_rdata [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] chan_hit;

    assign wr_ratio_high = REG_WR_I && (REG_ADDR_I == ADDR_PLL_RATIO_HIGH);
    assign wr_ratio_low = REG_WR_I && (REG_ADDR_I == ADDR_PLL_RATIO_LOW);
    assign wr_clk_ctl = REG_WR_I && (REG_ADDR_I == ADDR_CLOCK_GENERATOR_CONTROL);
    assign wr_phase = REG_WR_I && (REG_ADDR_I == ADDR_SAMPLING_PHASE);

    // divide ratio: high byte staged, whole ratio taken on low write
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            ratio_high_r <= RATIO_HIGH_RESET;
            ratio_low_r <= RATIO_LOW_RESET;
            ratio_active_r <= RATIO_RESET;
        end else begin
            if (wr_ratio_high) begin
                ratio_high_r <= REG_WDATA_I;
            end
            if (wr_ratio_low) begin
                ratio_low_r <= REG_WDATA_I[RATIO_LOW_LSB +: RATIO_LOW_W];
                ratio_active_r <= {ratio_high_r, REG_WDATA_I[RATIO_LOW_LSB +: RATIO_LOW_W]};
            end
        end
    end

    // clock generator control and phase
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            range_r <= RANGE_RESET;
            pump_r <= PUMP_RESET;
            ext_clock_r <= EXT_CLOCK_RESET;
            phase_r <= PHASE_RESET;
        end else begin
            if (wr_clk_ctl) begin
                range_r <= REG_WDATA_I[RANGE_LSB +: RANGE_W];
                pump_r <= REG_WDATA_I[PUMP_LSB +: PUMP_W];
                ext_clock_r <= REG_WDATA_I[EXT_CLOCK_BIT];
            end
            if (wr_phase) begin
                phase_r <= REG_WDATA_I[PHASE_LSB +: PHASE_W];
            end
        end
    end

    // per channel gain and offset pairs
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
        logic wr_gain_high;
        logic wr_gain_low;
        logic wr_off_high;
        logic wr_off_low;
        logic [7:0] a_gh;
        logic [7:0] a_gl;
        logic [7:0] a_oh;
        logic [7:0] a_ol;

        assign a_gh = chan_addr(ADDR_GAIN_HIGH_BASE, ch, 1'b0);
        assign a_gl = chan_addr(ADDR_GAIN_HIGH_BASE, ch, 1'b1);
        assign a_oh = chan_addr(ADDR_OFFSET_HIGH_BASE, ch, 1'b0);
        assign a_ol = chan_addr(ADDR_OFFSET_HIGH_BASE, ch, 1'b1);
        assign wr_gain_high = REG_WR_I && (REG_ADDR_I == a_gh);
        assign wr_gain_low = REG_WR_I && (REG_ADDR_I == a_gl);
        assign wr_off_high = REG_WR_I && (REG_ADDR_I == a_oh);
        assign wr_off_low = REG_WR_I && (REG_ADDR_I == a_ol);

        always_ff @(posedge CLOCK_I or posedge RST_I) begin
            if (RST_I) begin
                gain_high_r[ch] <= GAIN_HIGH_RESET;
                gain_low_r[ch] <= GAIN_LOW_RESET;
                gain_active_r[ch] <= {GAIN_HIGH_RESET, GAIN_LOW_RESET};
            end else begin
                if (wr_gain_high) begin
                    gain_high_r[ch] <= REG_WDATA_I[GAIN_HIGH_W-1:0];
                end
                if (wr_gain_low) begin
                    gain_low_r[ch] <= REG_WDATA_I[GAIN_LOW_LSB +: GAIN_LOW_W];
                    gain_active_r[ch] <= {gain_high_r[ch],
                                          REG_WDATA_I[GAIN_LOW_LSB +: GAIN_LOW_W]};
                end
            end
        end

        always_ff @(posedge CLOCK_I or posedge RST_I) begin
            if (RST_I) begin
                offset_high_r[ch] <= OFFSET_HIGH_RESET;
                offset_low_r[ch] <= OFFSET_LOW_RESET;
                offset_raw_r[ch] <= {OFFSET_HIGH_RESET, OFFSET_LOW_RESET};
            end else begin
                if (wr_off_high) begin
                    offset_high_r[ch] <= REG_WDATA_I;
                end
                if (wr_off_low) begin
                    offset_low_r[ch] <= REG_WDATA_I[OFFSET_LOW_LSB +: OFFSET_LOW_W];
                    offset_raw_r[ch] <= {offset_high_r[ch],
                                         REG_WDATA_I[OFFSET_LOW_LSB +: OFFSET_LOW_W]};
                end
            end
        end

        // two's complement keeps each step of one a step of one code
        always_ff @(posedge CLOCK_I or posedge RST_I) begin
            if (RST_I) begin
                offset_out_r[ch] <= '0;
            end else begin
                offset_out_r[ch] <= offset_resolve(offset_raw_r[ch], AUTO_OFFSET_EN_I);
            end
        end

        // readback of this channel's four registers
        always_comb begin
            chan_hit[ch] = 1'b1;
            chan_rdata[ch] = UNMAPPED_READ;
            if (REG_ADDR_I == a_gh) begin
                chan_rdata[ch] = {1'b0, gain_high_r[ch]};
            end else if (REG_ADDR_I == a_gl) begin
                chan_rdata[ch] = {gain_low_r[ch], 6'h00};
            end else if (REG_ADDR_I == a_oh) begin
                chan_rdata[ch] = offset_high_r[ch];
            end else if (REG_ADDR_I == a_ol) begin
                chan_rdata[ch] = {offset_low_r[ch], 5'h00};
            end else begin
                chan_hit[ch] = 1'b0;
            end
        end
    end

    // read multiplexer, reserved bits read zero
    always_comb begin
        rdata_nxt = UNMAPPED_READ;
        unique case (REG_ADDR_I)
            ADDR_SILICON_REVISION: rdata_nxt = SILICON_REVISION;
            ADDR_PLL_RATIO_HIGH: rdata_nxt = ratio_high_r;
            ADDR_PLL_RATIO_LOW: rdata_nxt = {ratio_low_r, 4'h0};
            ADDR_CLOCK_GENERATOR_CONTROL: rdata_nxt = {range_r, pump_r, ext_clock_r, 2'b00};
            ADDR_SAMPLING_PHASE: rdata_nxt = {phase_r, 3'b000};
            default: begin
                for (int i = 0; i < NUM_CHANNELS; i++) begin
                    if (chan_hit[i]) begin
                        rdata_nxt = chan_rdata[i];
                    end
                end
            end
        endcase
    end

    // read answer, one cycle after the strobe
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_RDATA_O <= UNMAPPED_READ;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
            if (REG_RD_I) begin
                REG_RDATA_O <= rdata_nxt;
            end
        end
    end

    // registered control outputs
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            LINE_DIVIDE_RATIO_O <= RATIO_RESET;
            LINE_DIVIDE_RATIO_USED_O <= ~EXT_CLOCK_RESET;
            VCO_RANGE_O <= RANGE_RESET;
            POST_DIVIDE_SHIFT_O <= ~RANGE_RESET;
            PUMP_CURRENT_CODE_O <= PUMP_RESET;
            PUMP_CURRENT_UA_O <= PUMP_UA_1;
            EXTERNAL_PIXEL_CLOCK_SEL_O <= EXT_CLOCK_RESET;
            SAMPLE_PHASE_O <= PHASE_RESET;
            SAMPLE_PHASE_CDEG_O <= 16'(PHASE_RESET * PHASE_STEP_CDEG);
            AUTO_OFFSET_MODE_O <= 1'b0;
        end else begin
            LINE_DIVIDE_RATIO_O <= ratio_active_r;
            LINE_DIVIDE_RATIO_USED_O <= ~ext_clock_r;
            VCO_RANGE_O <= range_r;
            POST_DIVIDE_SHIFT_O <= ~range_r;
            PUMP_CURRENT_CODE_O <= pump_r;
            PUMP_CURRENT_UA_O <= pump_ua(pump_r);
            EXTERNAL_PIXEL_CLOCK_SEL_O <= ext_clock_r;
            SAMPLE_PHASE_O <= phase_r;
            SAMPLE_PHASE_CDEG_O <= 16'({11'h000, phase_r} * PHASE_STEP_CDEG);
            AUTO_OFFSET_MODE_O <= AUTO_OFFSET_EN_I;
        end
    end

    assign RED_GAIN_O = gain_active_r[0];
    assign GREEN_GAIN_O = gain_active_r[1];
    assign BLUE_GAIN_O = gain_active_r[2];
    assign RED_OFFSET_O = offset_out_r[0];
    assign GREEN_OFFSET_O = offset_out_r[1];
    assign BLUE_OFFSET_O = offset_out_r[2];

endmodule

`default_nettype wire

// [include/vapgo_pkg.sv]
// register map, field layout and reset values of the video pll/gain/offset register bank
`default_nettype none
package vapgo_pkg;

    // register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] ADDR_SILICON_REVISION = 8'h00;
    localparam logic [7:0] ADDR_PLL_RATIO_HIGH = 8'h01;
    localparam logic [7:0] ADDR_PLL_RATIO_LOW = 8'h02;
    localparam logic [7:0] ADDR_CLOCK_GENERATOR_CONTROL = 8'h03;
    localparam logic [7:0] ADDR_SAMPLING_PHASE = 8'h04;
    localparam logic [7:0] ADDR_GAIN_HIGH_BASE = 8'h05;
    localparam logic [7:0] ADDR_OFFSET_HIGH_BASE = 8'h0b;
    localparam logic [7:0] ADDR_CHANNEL_STRIDE = 8'h02;
    localparam logic [7:0] ADDR_LOW_STEP = 8'h01;

    // channels, in address order: red, green, blue
    localparam int NUM_CHANNELS = 3;

    // field widths
    localparam int RATIO_W = 12;
    localparam int RATIO_LOW_W = 4;
    localparam int RANGE_W = 2;
    localparam int PUMP_W = 3;
    localparam int PHASE_W = 5;
    localparam int GAIN_W = 9;
    localparam int GAIN_HIGH_W = 7;
    localparam int GAIN_LOW_W = 2;
    localparam int OFFSET_W = 11;
    localparam int OFFSET_HIGH_W = 8;
    localparam int OFFSET_LOW_W = 3;
    localparam int OFFSET_MANUAL_W = 9;
    localparam int PUMP_UA_W = 11;
    localparam int PHASE_CDEG_W = 16;

    // field positions
    localparam int RATIO_LOW_LSB = 4;
    localparam int RANGE_LSB = 6;
    localparam int PUMP_LSB = 3;
    localparam int EXT_CLOCK_BIT = 2;
    localparam int PHASE_LSB = 3;
    localparam int GAIN_LOW_LSB = 6;
    localparam int OFFSET_LOW_LSB = 5;

    // reset values
    localparam logic [11:0] RATIO_RESET = 12'd1693;
    localparam logic [7:0] RATIO_HIGH_RESET = 8'h69;
    localparam logic [3:0] RATIO_LOW_RESET = 4'hd;
    localparam logic [1:0] RANGE_RESET = 2'h1;
    localparam logic [2:0] PUMP_RESET = 3'h1;
    localparam logic EXT_CLOCK_RESET = 1'b0;
    localparam logic [4:0] PHASE_RESET = 5'h10;
    localparam logic [6:0] GAIN_HIGH_RESET = 7'h40;
    localparam logic [1:0] GAIN_LOW_RESET = 2'h0;
    localparam logic [7:0] OFFSET_HIGH_RESET = 8'h00;
    localparam logic [2:0] OFFSET_LOW_RESET = 3'h0;

    // phase step in hundredths of a degree (11.25 degrees)
    localparam logic [15:0] PHASE_STEP_CDEG = 16'd1125;

    // charge pump current per code, microamps
    localparam logic [10:0] PUMP_UA_0 = 11'd50;
    localparam logic [10:0] PUMP_UA_1 = 11'd100;
    localparam logic [10:0] PUMP_UA_2 = 11'd150;
    localparam logic [10:0] PUMP_UA_3 = 11'd250;
    localparam logic [10:0] PUMP_UA_4 = 11'd350;
    localparam logic [10:0] PUMP_UA_5 = 11'd500;
    localparam logic [10:0] PUMP_UA_6 = 11'd750;
    localparam logic [10:0] PUMP_UA_7 = 11'd1500;

    // clock generator range codes
    typedef enum logic [1:0] {
        VAPGO_RANGE_10_31 = 2'h0,
        VAPGO_RANGE_31_62 = 2'h1,
        VAPGO_RANGE_62_124 = 2'h2,
        VAPGO_RANGE_124_170 = 2'h3
    } vapgo_range_t;

    // read data of an unmapped address
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

`default_nettype wire

// [verif/vapgo_host.sv]
// host model: issues register writes and reads on the strobe interface
`timescale 1ns/1ps
`default_nettype none
module vapgo_host (
    // clock
    input wire logic clk_i,
    // request side
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o,
    // answer side
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        addr_o <= ~a;
        wdata_o <= ~d;
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        addr_o <= ~a;
        rd_o <= 1'b0;
        @(posedge clk_i);
        ok = rvalid_i;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// [verif/vapgo_regs_properties.sv]
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module vapgo_regs_checker (
    // clock, reset, writes
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic AUTO_OFFSET_EN_I,
    // clock generator and phase
    input wire logic [11:0] LINE_DIVIDE_RATIO_O,
    input wire logic LINE_DIVIDE_RATIO_USED_O,
    input wire logic [1:0] VCO_RANGE_O,
    input wire logic [1:0] POST_DIVIDE_SHIFT_O,
    input wire logic [2:0] PUMP_CURRENT_CODE_O,
    input wire logic [10:0] PUMP_CURRENT_UA_O,
    input wire logic EXTERNAL_PIXEL_CLOCK_SEL_O,
    input wire logic [4:0] SAMPLE_PHASE_O,
    input wire logic [15:0] SAMPLE_PHASE_CDEG_O,
    // red channel
    input wire logic [8:0] RED_GAIN_O,
    input wire logic [10:0] RED_OFFSET_O
);
    logic [7:0] rhi_r;
    logic [6:0] ghi_r;
    logic [7:0] ohi_r;
    logic [10:0] ua_tab [8] = '{11'd50, 11'd100, 11'd150, 11'd250, 11'd350, 11'd500,
        11'd750, 11'd1500};
    wire logic rlo_wr = REG_WR_I && REG_ADDR_I == 8'h02;
    wire logic ctl_wr = REG_WR_I && REG_ADDR_I == 8'h03;
    wire logic glo_wr = REG_WR_I && REG_ADDR_I == 8'h06;
    wire logic olo_wr = REG_WR_I && REG_ADDR_I == 8'h0c;
    wire logic [11:0] r_exp = {rhi_r, REG_WDATA_I[7:4]};
    wire logic [8:0] g_exp = {ghi_r, REG_WDATA_I[7:6]};
    wire logic [10:0] o_exp = {ohi_r, REG_WDATA_I[7:5]};
    wire logic [10:0] m_exp = {{2{ohi_r[6]}}, ohi_r[6:0], REG_WDATA_I[7:6]};
    // staged high bytes as written
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            rhi_r <= 8'h69;
            ghi_r <= 7'h40;
            ohi_r <= 8'h00;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == 8'h01) rhi_r <= REG_WDATA_I;
            if (REG_ADDR_I == 8'h05) ghi_r <= REG_WDATA_I[6:0];
            if (REG_ADDR_I == 8'h0b) ohi_r <= REG_WDATA_I;
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    ratio_hold_a: assert property ($changed(LINE_DIVIDE_RATIO_O) |-> $past(rlo_wr, 2))
        else $error("ratio moved without low write");
    ratio_load_a: assert property (rlo_wr |-> ##2 LINE_DIVIDE_RATIO_O == $past(r_exp, 2))
        else $error("ratio not loaded");
    gain_load_a: assert property (glo_wr |=> RED_GAIN_O == $past(g_exp))
        else $error("gain not loaded");
    gain_hold_a: assert property ($changed(RED_GAIN_O) |-> $past(glo_wr))
        else $error("gain moved without low write");
    ctrl_apply_a: assert property (
        ctl_wr |-> ##2 {VCO_RANGE_O, PUMP_CURRENT_CODE_O, EXTERNAL_PIXEL_CLOCK_SEL_O, 2'b00}
        == ($past(REG_WDATA_I, 2) & 8'hfc)) else $error("control field wrong");
    post_div_a: assert property (POST_DIVIDE_SHIFT_O == ~VCO_RANGE_O)
        else $error("post divider wrong");
    pump_map_a: assert property (PUMP_CURRENT_UA_O == ua_tab[PUMP_CURRENT_CODE_O])
        else $error("pump current wrong");
    ext_clock_a: assert property (LINE_DIVIDE_RATIO_USED_O != EXTERNAL_PIXEL_CLOCK_SEL_O)
        else $error("ratio use wrong");
    phase_deg_a: assert property (
        SAMPLE_PHASE_CDEG_O == {11'h000, SAMPLE_PHASE_O} * 16'd1125) else $error("phase wrong");
    auto_offs_a: assert property (
        olo_wr ##1 AUTO_OFFSET_EN_I |=> RED_OFFSET_O == $past(o_exp, 2))
        else $error("auto offset wrong");
    man_offs_a: assert property (
        olo_wr ##1 !AUTO_OFFSET_EN_I |=> RED_OFFSET_O == $past(m_exp, 2))
        else $error("manual offset wrong");
    cover property (rlo_wr);
    cover property (ctl_wr ##2 EXTERNAL_PIXEL_CLOCK_SEL_O);
    cover property (olo_wr ##1 AUTO_OFFSET_EN_I);
endmodule
bind vapgo_regs vapgo_regs_checker u_vapgo_regs_checker (
    .CLOCK_I, .RST_I, .REG_ADDR_I, .REG_WR_I, .REG_WDATA_I, .AUTO_OFFSET_EN_I,
    .LINE_DIVIDE_RATIO_O, .LINE_DIVIDE_RATIO_USED_O, .VCO_RANGE_O, .POST_DIVIDE_SHIFT_O,
    .PUMP_CURRENT_CODE_O, .PUMP_CURRENT_UA_O, .EXTERNAL_PIXEL_CLOCK_SEL_O, .SAMPLE_PHASE_O,
    .SAMPLE_PHASE_CDEG_O, .RED_GAIN_O, .RED_OFFSET_O
);
`default_nettype wire

// [verif/tb_video_adc_pll_gain_offset_regs.sv]
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_video_adc_pll_gain_offset_regs;
    localparam logic [7:0] REV = 8'h3c; // arbitrary value
    logic clk, rst, auto_en, wr, rd, rvalid, used, ext, mode;
    logic [7:0] addr, wdata, rdata, d;
    logic [11:0] ratio, er;
    logic [1:0] range, post;
    logic [2:0] pump;
    logic [10:0] ua, e;
    logic [4:0] phase;
    logic [15:0] cdeg;
    logic [8:0] gain [3];
    logic [10:0] offs [3];
    logic [10:0] ua_tab [8] = '{11'd50, 11'd100, 11'd150, 11'd250, 11'd350, 11'd500,
        11'd750, 11'd1500};
    logic [7:0] rst_tab [17] = '{8'h00, 8'h69, 8'hd0, 8'h48, 8'h80, 8'h40, 8'h00, 8'h40,
        8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] rhi [3] = '{8'h12, 8'h00, 8'hff};
    logic [7:0] rlo [3] = '{8'h30, 8'h20, 8'hf0};
    logic [7:0] ohi [7] = '{8'h7f, 8'h00, 8'h00, 8'h3f, 8'h40, 8'h42, 8'h42};
    logic [7:0] olo [7] = '{8'hc0, 8'h40, 8'h80, 8'hc0, 8'h40, 8'h40, 8'h60};
    int fail_count = 0;
    int num_checks = 0;
    vapgo_regs #(.SILICON_REVISION(REV)) u_vapgo_regs (
        .CLOCK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .AUTO_OFFSET_EN_I(auto_en),
        .LINE_DIVIDE_RATIO_O(ratio), .LINE_DIVIDE_RATIO_USED_O(used), .VCO_RANGE_O(range),
        .POST_DIVIDE_SHIFT_O(post), .PUMP_CURRENT_CODE_O(pump), .PUMP_CURRENT_UA_O(ua),
        .EXTERNAL_PIXEL_CLOCK_SEL_O(ext), .SAMPLE_PHASE_O(phase), .SAMPLE_PHASE_CDEG_O(cdeg),
        .RED_GAIN_O(gain[0]), .GREEN_GAIN_O(gain[1]), .BLUE_GAIN_O(gain[2]),
        .AUTO_OFFSET_MODE_O(mode), .RED_OFFSET_O(offs[0]), .GREEN_OFFSET_O(offs[1]),
        .BLUE_OFFSET_O(offs[2]));
    vapgo_host u_vapgo_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
        .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic ok;
        u_vapgo_host.rd(a, v, ok);
        chk("rvalid", 16'(ok), 16'h1);
        chk($sformatf("reg %h", a), 16'(v), 16'(exp));
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] v);
        u_vapgo_host.wr(a, v);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    // manual offset: nine bits, sign extended
    function automatic logic [10:0] man(input logic [7:0] h, input logic [7:0] l);
        return {{2{h[6]}}, h[6:0], l[7:6]};
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("Error watchdog expected finish seen hang");
        wrap_up;
    end
    initial begin
        rst = 1'b1;
        auto_en = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rc(8'h00, REV);
        for (int i = 1; i < 17; i++) rc(8'(i), rst_tab[i]);
        chk("ratio", 16'(ratio), 16'd1693);
        chk("ua", 16'({used, ua}), 16'h0864);
        chk("cdeg", cdeg, 16'd18000);
        for (int c = 0; c < 3; c++) chk("gain", 16'(gain[c]), 16'h100);
        $display("test reset done");
        er = 12'd1693;
        for (int k = 0; k < 3; k++) begin
            w(8'h01, rhi[k]);
            settle;
            chk("ratio held", 16'(ratio), 16'(er));
            rc(8'h01, rhi[k]);
            w(8'h02, rlo[k]);
            settle;
            er = {rhi[k], rlo[k][7:4]};
            chk("ratio", 16'(ratio), 16'(er));
            rc(8'h02, rlo[k] & 8'hf0);
        end
        $display("test ratio done");
        for (int i = 0; i < 8; i++) begin
            d = {i[1:0], i[2:0], i[0], 2'b11};
            w(8'h03, d);
            w(8'h04, {5'(i * 4 + 3), 3'b111});
            settle;
            chk("range", 16'({range, post}), 16'({i[1:0], ~i[1:0]}));
            chk("pump", 16'(pump), 16'(i[2:0]));
            chk("ua", 16'(ua), 16'(ua_tab[i]));
            chk("ext", 16'({ext, used}), 16'({i[0], !i[0]}));
            chk("ratio kept", 16'(ratio), 16'(er));
            chk("phase", cdeg, 16'(i * 4 + 3) * 16'd1125);
            chk("phase step", 16'(phase), 16'(i * 4 + 3));
            rc(8'h03, d & 8'hfc);
            rc(8'h04, {5'(i * 4 + 3), 3'b000});
        end
        $display("test clock done");
        for (int c = 0; c < 3; c++) begin
            w(8'(5 + 2 * c), 8'hff);
            settle;
            chk("gain held", 16'(gain[c]), 16'h100);
            rc(8'(5 + 2 * c), 8'h7f);
            w(8'(6 + 2 * c), 8'hff);
            settle;
            chk("gain", 16'(gain[c]), 16'h1ff);
            rc(8'(6 + 2 * c), 8'hc0);
        end
        $display("test gain done");
        for (int m = 0; m < 2; m++) begin
            auto_en <= m[0];
            for (int c = 0; c < 3; c++) begin
                for (int k = 0; k < 7; k++) begin
                    w(8'(11 + 2 * c), ohi[k]);
                    w(8'(12 + 2 * c), olo[k]);
                    settle;
                    e = m[0] ? {ohi[k], olo[k][7:5]} : man(ohi[k], olo[k]);
                    chk("offset", 16'(offs[c]), 16'(e));
                end
            end
            chk("mode", 16'(mode), 16'(m[0]));
        end
        auto_en <= 1'b0;
        settle;
        chk("offset mode", 16'(offs[2]), 16'(man(8'h42, 8'h60)));
        $display("test offset done");
        w(8'h00, ~REV);
        w(8'h11, 8'ha5);
        rc(8'h00, REV);
        rc(8'h11, 8'h00);
        rc(8'hff, 8'h00);
        rst <= 1'b1;
        settle;
        rst <= 1'b0;
        rc(8'h01, 8'h69);
        chk("ratio", 16'(ratio), 16'd1693);
        $display("test refuse done");
        wrap_up;
    end
endmodule
`default_nettype wire
